// ===== swx_pkg.sv
package swx_pkg;
    // Exchange framing
    localparam int CFG_BITS = 4;
    localparam int RES_BITS = 12;
    localparam logic [1:0] CFG_LAST = 2'h3;
    // Positions within the 4-bit configuration word, first bit highest
    localparam int CFG_SINGLE_POS = 3;
    localparam int CFG_ODD_POS = 2;
    localparam int CFG_ORDER_POS = 1;
    localparam int CFG_SHDN_N_POS = 0;
    // Output bit index after the null bit
    localparam logic [4:0] IDX_MSB_LAST = 5'h0B;
    localparam logic [4:0] IDX_LSB_LAST = 5'h16;
    localparam logic [4:0] IDX_LSB_BASE = 5'h0B;
    // Shutdown exchange word
    localparam logic [11:0] SHDN_WORD = 12'hFFF;
    // Reset values
    localparam logic [11:0] RES_RST = 12'h000;
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [4:0] IDX_RST = 5'h00;
    localparam logic [1:0] CNT_RST = 2'h0;

    // Gray coded along idle, hunt, config, null, data, fill
    typedef enum logic [2:0] {
        SWX_IDLE = 3'h0,
        SWX_HUNT = 3'h1,
        SWX_CFG = 3'h3,
        SWX_NULL = 3'h2,
        SWX_DATA = 3'h6,
        SWX_FILL = 3'h7
    } swx_state_t;
endpackage

// ===== swx_pins_if.sv
interface swx_pins_if;
    logic cs_n;
    logic din;
    logic sclk_rise;
    logic sclk_fall;
    modport sync (output cs_n, output din, output sclk_rise,
                  output sclk_fall);
    modport core (input cs_n, input din, input sclk_rise,
                  input sclk_fall);
endinterface

// ===== swx_pin_sync.sv
module swx_pin_sync (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    swx_pins_if.sync pins
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic sclk_d_r;

    // Two flops per pin; first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= 3'h4;
            sync_r <= 3'h4;
        end else begin
            meta_r <= {i_cs_n, i_sclk, i_din};
            sync_r <= meta_r;
        end
    end

    // Delayed clock level for edge detection
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sync_r[1];
        end
    end

    // Edges are one system cycle wide
    assign pins.cs_n = sync_r[2];
    assign pins.din = sync_r[0];
    assign pins.sclk_rise = sync_r[1] & ~sclk_d_r;
    assign pins.sclk_fall = ~sync_r[1] & sclk_d_r;
endmodule

// ===== swx_serial_exchange.sv
module swx_serial_exchange (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic [11:0] i_code,
    output logic o_dout,
    output logic o_dout_oe_n,
    output logic o_conv_start,
    output logic o_single_ended,
    output logic o_odd_sign,
    output logic o_shutdown,
    output logic o_active
);
    swx_pins_if pins ();

    swx_pkg::swx_state_t state_r;
    logic [1:0] cnt_r;
    logic [2:0] cfg_r;
    logic [4:0] idx_r;
    logic [11:0] res_r;
    logic lsb_mode_r;
    logic dout_r;
    logic oe_n_r;
    logic start_r;
    logic single_r;
    logic odd_r;
    logic shdn_r;
    logic active_r;
    logic cfg_done;
    logic [3:0] cfg_word;
    logic [4:0] last_idx;

    swx_pin_sync u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cs_n(i_cs_n),
        .i_sclk(i_sclk),
        .i_din(i_din),
        .pins(pins)
    );

    // Bit to send at a given index after the null bit
    function automatic logic bit_at(input logic [11:0] code,
                                    input logic [4:0] idx);
        logic b;
        b = 1'b0;
        if (idx <= swx_pkg::IDX_MSB_LAST) begin
            b = code[4'(swx_pkg::IDX_MSB_LAST - idx)];
        end else if (idx <= swx_pkg::IDX_LSB_LAST) begin
            b = code[4'(idx - swx_pkg::IDX_LSB_BASE)];
        end
        return b;
    endfunction

    // Fourth config bit is taken on this rising edge
    assign cfg_done = (state_r == swx_pkg::SWX_CFG) && pins.sclk_rise
                      && (cnt_r == swx_pkg::CFG_LAST);
    assign cfg_word = {cfg_r, pins.din};
    // LSB-first repeat lengthens the data phase
    assign last_idx = lsb_mode_r ? swx_pkg::IDX_LSB_LAST
                                 : swx_pkg::IDX_MSB_LAST;

    // Exchange sequencing; select high always resets it
    always_ff @(posedge i_clk) begin
        if (i_rst || pins.cs_n) begin
            state_r <= swx_pkg::SWX_IDLE;
        end else begin
            case (state_r)
                swx_pkg::SWX_IDLE: begin
                    state_r <= swx_pkg::SWX_HUNT;
                end
                swx_pkg::SWX_HUNT: begin
                    // Leading zeros skipped
                    if (pins.sclk_rise && pins.din) begin
                        state_r <= swx_pkg::SWX_CFG;
                    end
                end
                swx_pkg::SWX_CFG: begin
                    if (cfg_done) begin
                        state_r <= swx_pkg::SWX_NULL;
                    end
                end
                swx_pkg::SWX_NULL: begin
                    if (pins.sclk_fall) begin
                        state_r <= swx_pkg::SWX_DATA;
                    end
                end
                swx_pkg::SWX_DATA: begin
                    if (pins.sclk_fall && idx_r == last_idx) begin
                        state_r <= swx_pkg::SWX_FILL;
                    end
                end
                swx_pkg::SWX_FILL: begin
                    state_r <= swx_pkg::SWX_FILL;
                end
                default: begin
                    state_r <= swx_pkg::SWX_IDLE;
                end
            endcase
        end
    end

    // Config shift; input ignored outside this phase
    always_ff @(posedge i_clk) begin
        if (i_rst || state_r == swx_pkg::SWX_HUNT) begin
            cnt_r <= swx_pkg::CNT_RST;
            cfg_r <= swx_pkg::CFG_RST;
        end else if (state_r == swx_pkg::SWX_CFG && pins.sclk_rise) begin
            cnt_r <= cnt_r + 2'h1;
            cfg_r <= {cfg_r[1:0], pins.din};
        end
    end

    // Decode the config word; start is a one-cycle pulse
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            start_r <= 1'b0;
            single_r <= 1'b0;
            odd_r <= 1'b0;
            lsb_mode_r <= 1'b0;
        end else begin
            start_r <= cfg_done && cfg_word[swx_pkg::CFG_SHDN_N_POS];
            if (cfg_done) begin
                single_r <= cfg_word[swx_pkg::CFG_SINGLE_POS];
                odd_r <= cfg_word[swx_pkg::CFG_ODD_POS];
                // Shutdown word is never repeated LSB first
                lsb_mode_r <= !cfg_word[swx_pkg::CFG_ORDER_POS]
                              && cfg_word[swx_pkg::CFG_SHDN_N_POS];
            end
        end
    end

    // Shutdown holds until the next select cycle begins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            shdn_r <= 1'b0;
        end else if (cfg_done) begin
            shdn_r <= !cfg_word[swx_pkg::CFG_SHDN_N_POS];
        end else if (state_r == swx_pkg::SWX_IDLE && !pins.cs_n) begin
            shdn_r <= 1'b0;
        end
    end

    // Result frozen at the null bit; code passed as straight binary
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            res_r <= swx_pkg::RES_RST;
        end else if (state_r == swx_pkg::SWX_NULL && pins.sclk_fall) begin
            res_r <= shdn_r ? swx_pkg::SHDN_WORD : i_code;
        end
    end

    // Output bit index
    always_ff @(posedge i_clk) begin
        if (i_rst || state_r != swx_pkg::SWX_DATA) begin
            idx_r <= swx_pkg::IDX_RST;
        end else if (pins.sclk_fall) begin
            idx_r <= idx_r + 5'h01;
        end
    end

    // Data pin; driven only from the null bit on, so a shared wire
    // is free while the host sends config bits
    always_ff @(posedge i_clk) begin
        if (i_rst || pins.cs_n) begin
            dout_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (pins.sclk_fall) begin
            case (state_r)
                swx_pkg::SWX_NULL: begin
                    dout_r <= 1'b0;
                    oe_n_r <= 1'b0;
                end
                swx_pkg::SWX_DATA: begin
                    dout_r <= bit_at(res_r, idx_r);
                end
                swx_pkg::SWX_FILL: begin
                    dout_r <= 1'b0;
                end
                default: begin
                    dout_r <= dout_r;
                end
            endcase
        end
    end

    // Busy indication for the analog side
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            active_r <= 1'b0;
        end else begin
            active_r <= !pins.cs_n && state_r != swx_pkg::SWX_IDLE
                        && state_r != swx_pkg::SWX_HUNT;
        end
    end

    assign o_dout = dout_r;
    assign o_dout_oe_n = oe_n_r;
    assign o_conv_start = start_r;
    assign o_single_ended = single_r;
    assign o_odd_sign = odd_r;
    assign o_shutdown = shdn_r;
    assign o_active = active_r;

    property p_hunt_skips_zero;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == swx_pkg::SWX_HUNT && !pins.cs_n && pins.sclk_rise
         && !pins.din) |=> state_r == swx_pkg::SWX_HUNT;
    endproperty
    a_hunt_skips_zero: assert property (p_hunt_skips_zero)
        else $error("zero bit left start hunt");

    property p_cfg_to_null;
        @(posedge i_clk) disable iff (i_rst)
        (cfg_done && !pins.cs_n) |=> state_r == swx_pkg::SWX_NULL;
    endproperty
    a_cfg_to_null: assert property (p_cfg_to_null)
        else $error("fourth config bit did not end config");

    property p_null_bit;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == swx_pkg::SWX_NULL && pins.sclk_fall && !pins.cs_n)
        |=> (!o_dout && !o_dout_oe_n);
    endproperty
    a_null_bit: assert property (p_null_bit)
        else $error("null bit not driven low");

    property p_dout_on_fall;
        @(posedge i_clk) disable iff (i_rst)
        $changed(o_dout) |-> ($past(pins.sclk_fall) || $past(pins.cs_n));
    endproperty
    a_dout_on_fall: assert property (p_dout_on_fall)
        else $error("data changed away from falling edge");

    property p_fill_zero;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == swx_pkg::SWX_FILL && pins.sclk_fall && !pins.cs_n)
        |=> !o_dout;
    endproperty
    a_fill_zero: assert property (p_fill_zero)
        else $error("fill bit not zero");

    property p_lsb_first;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == swx_pkg::SWX_DATA && pins.sclk_fall && !pins.cs_n
         && lsb_mode_r && idx_r == 5'h0C) |=> o_dout == $past(res_r[1]);
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("LSB-first repeat wrong");

    property p_shutdown_entry;
        @(posedge i_clk) disable iff (i_rst)
        (cfg_done && !cfg_word[swx_pkg::CFG_SHDN_N_POS])
        |=> (o_shutdown && !o_conv_start);
    endproperty
    a_shutdown_entry: assert property (p_shutdown_entry)
        else $error("shutdown not entered");

    property p_shutdown_ones;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == swx_pkg::SWX_DATA && shdn_r && pins.sclk_fall
         && !pins.cs_n) |=> o_dout;
    endproperty
    a_shutdown_ones: assert property (p_shutdown_ones)
        else $error("shutdown word bit not one");

    property p_float_on_deselect;
        @(posedge i_clk) disable iff (i_rst)
        pins.cs_n |=> o_dout_oe_n;
    endproperty
    a_float_on_deselect: assert property (p_float_on_deselect)
        else $error("output driven while deselected");

    property p_shutdown_exit;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == swx_pkg::SWX_IDLE && !pins.cs_n) |=> ##1 !o_shutdown;
    endproperty
    a_shutdown_exit: assert property (p_shutdown_exit)
        else $error("shutdown kept after select fell");

    c_conversion: cover property (@(posedge i_clk) disable iff (i_rst)
        o_conv_start);
    c_lsb_repeat: cover property (@(posedge i_clk) disable iff (i_rst)
        state_r == swx_pkg::SWX_FILL && lsb_mode_r);
    c_shutdown: cover property (@(posedge i_clk) disable iff (i_rst)
        state_r == swx_pkg::SWX_FILL && shdn_r);
endmodule

// ===== swx_host_model.sv
// Bit-banged host on four port lines
module swx_host_model (
    input wire logic i_clk,
    input wire logic i_dout,
    input wire logic i_dout_oe_n,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din
);
    timeunit 1ns;
    timeprecision 1ns;
    // Half shift period in system clocks, above the 3 the device needs
    localparam int HALF = 6;
    logic pin;

    // Floats when the device lets go, so stale data never passes
    assign pin = i_dout_oe_n ? 1'bz : i_dout;

    // Idle levels: deselected, shift clock low
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end

    // One framed exchange; rx holds every bit seen on a rise
    task automatic frame(input int nlead, input logic [3:0] cfg,
                         input int nrx, output logic [63:0] rx);
        int i;
        rx = '0;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        repeat (HALF) @(negedge i_clk);
        // Data changes while the clock is low
        for (i = 0; i < nlead + 5 + nrx; i++) begin
            if (i < nlead)
                o_din = 1'b0; // Leading zeros
            else if (i == nlead)
                o_din = 1'b1; // Start bit
            else if (i < nlead + 5)
                o_din = cfg[nlead + 4 - i]; // Word
            else
                o_din = ~o_din; // Junk after the word
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b1;
            rx = {rx[62:0], pin}; // Sampled at the rise
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (HALF) @(negedge i_clk);
        o_cs_n = 1'b1;
        repeat (2 * HALF) @(negedge i_clk);
    endtask
endmodule

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic i_rst;
    logic cs_n;
    logic sclk;
    logic din;
    logic [11:0] code;
    logic o_dout;
    logic o_dout_oe_n;
    logic o_conv_start;
    logic o_single_ended;
    logic o_odd_sign;
    logic o_shutdown;
    logic o_active;
    int mismatches = 0;
    int n_compared = 0;
    int n_conv = 0;
    int n_launch_idle = 0;

    swx_serial_exchange i_dut (
        .i_clk(clk),
        .i_rst(i_rst),
        .i_cs_n(cs_n),
        .i_sclk(sclk),
        .i_din(din),
        .i_code(code),
        .o_dout(o_dout),
        .o_dout_oe_n(o_dout_oe_n),
        .o_conv_start(o_conv_start),
        .o_single_ended(o_single_ended),
        .o_odd_sign(o_odd_sign),
        .o_shutdown(o_shutdown),
        .o_active(o_active)
    );

    swx_host_model i_host (
        .i_clk(clk),
        .i_dout(o_dout),
        .i_dout_oe_n(o_dout_oe_n),
        .o_cs_n(cs_n),
        .o_sclk(sclk),
        .o_din(din)
    );

    // 20 MHz system clock
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Launch pulses counted mid-cycle, since they stand one cycle only
    always @(negedge clk) begin
        if (o_conv_start === 1'b1) begin
            n_conv <= n_conv + 1;
            // A launch must fall inside the busy window
            if (o_active !== 1'b1)
                n_launch_idle <= n_launch_idle + 1;
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Bit-reversed copy of B11..B1, as sent after B0
    function automatic logic [10:0] rev11(input logic [11:0] v);
        int k;
        for (k = 0; k < 11; k++)
            rev11[10 - k] = v[k + 1];
    endfunction

    // MSB-first conversion with zero fill and mux levels
    task automatic t_msb(input logic [11:0] c, input logic [1:0] mux);
        logic [63:0] rx;
        int c0;
        @(negedge clk) code = c;
        c0 = n_conv;
        i_host.frame(2, {mux, 2'b11}, 21, rx);
        check(rx[20:0], {1'b0, c, 8'h00});
        check(rx[27:21], {7{1'bz}});
        check(n_launch_idle, 0);
        check(o_active, 1'b0);
        check(n_conv - c0, 1);
        check({o_single_ended, o_odd_sign}, mux);
        check(o_shutdown, 1'b0);
        check(o_dout_oe_n, 1'b1);
    endtask

    // Order bit clear: MSB-first then LSB-first repeat, then zeros
    task automatic t_lsb(input logic [11:0] c);
        logic [63:0] rx;
        @(negedge clk) code = c;
        i_host.frame(3, 4'b0101, 28, rx);
        check(rx[27:0], {1'b0, c, rev11(c), 4'h0});
        check({o_single_ended, o_odd_sign}, 2'b01);
    endtask

    // Shutdown word, order bit ignored, then instant next conversion
    task automatic t_shdn();
        logic [63:0] rx;
        int c0;
        @(negedge clk) code = 12'h123;
        c0 = n_conv;
        i_host.frame(1, 4'b1000, 17, rx);
        check(rx[16:0], {1'b0, 12'hFFF, 4'h0});
        check(n_conv - c0, 0);
        check(o_shutdown, 1'b1);
        check(o_dout_oe_n, 1'b1);
        t_msb(12'h7E1, 2'b10);
    endtask

    // Three byte transfers, right-justified result
    task automatic t_byte(input logic [11:0] c);
        logic [63:0] rx;
        @(negedge clk) code = c;
        i_host.frame(6, 4'b0011, 13, rx);
        check(rx[15:8] & 8'h0F, {4'h0, c[11:8]});
        check(rx[7:0], c[7:0]);
    endtask

    // Main sequence
    initial begin
        i_rst = 1'b1;
        code = 12'h000;
        repeat (6) @(negedge clk);
        i_rst = 1'b0;
        repeat (6) @(negedge clk);
        check(o_dout_oe_n, 1'b1);
        t_msb(12'h000, 2'b10);
        t_msb(12'hFFF, 2'b11);
        t_msb(12'h5A3, 2'b00);
        t_lsb(12'hA5C);
        t_shdn();
        t_byte(12'hC39);
        final_report();
    end

    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule
